//--- inc/lane_mask_pkg.sv
// Constants for the burst write lane-masking block.
// Assumes one system clock; beats arrive already sampled, one per clock cycle.
package lane_mask_pkg;
  // Widest part: four 9-bit lanes
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int WORD_W = LANE_W * LANES;
  // Nibble-wide part: two 4-bit lanes
  localparam int NIB_W = 4;
  // Words in one burst
  localparam int BURST_LEN = 4;
  localparam int BADDR_W = 2;
  // Array depth in burst locations held by this model
  localparam int DEPTH = 16;
  localparam int ADDR_W = 4;
  // Reset values
  localparam logic [BADDR_W-1:0] BEAT_RST = 2'h0;
  localparam logic [WORD_W-1:0] WORD_RST = 36'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;
  // Index of the fourth and last word of a burst
  localparam logic [BADDR_W-1:0] BEAT_LAST = 2'h3;
  // Part configurations
  typedef enum logic [1:0]
  {
    PART_X8 = 2'b00,
    PART_X9 = 2'b01,
    PART_X18 = 2'b10,
    PART_X36 = 2'b11
  } part_t;
endpackage

//--- core/burst_write_lane_mask.sv
// Write-port lane masking for a separate-I/O burst SRAM array.
// Assumes beats arrive as clk_sys-domain pulses from the input register stage.
//
// Notes on behaviour
// - Selects evaluated per beat, sampled with it
// - Two selects low: whole beat written
// - Only select 0 low: lower lane written
// - Only select 1 low: upper lane written
// - Both selects high: beat writes nothing
// - Nine-bit part: low select writes all
// - 36-bit part: all low writes all lanes
// - 36-bit part: select 0 writes bits 8:0
// - Selects 1..3 each write own lane
// - All selects high: no array write
// - Four beats follow the address cycle
`timescale 1ns/1ps
module burst_write_lane_mask
(
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic [1:0] part_sel, // Part configuration code
  input wire logic burst_start, // Write address taken this cycle
  input wire logic [3:0] burst_addr, // Burst base location
  input wire logic beat_valid, // One data beat present
  input wire logic [35:0] beat_data, // Beat data, low bits used on narrow parts
  input wire logic [3:0] lane_write_select_n, // Lane selects, active low
  input wire logic [1:0] half_word_write_select_n, // Nibble selects, x8 part
  input wire logic [3:0] rd_addr, // Read-back location
  input wire logic [1:0] rd_beat, // Read-back word in burst
  output logic [35:0] rd_data, // Registered read-back word
  output logic wr_done // Pulse: a beat updated the array
);
  // Storage: DEPTH locations of BURST_LEN words
  logic [35:0] mem_reg [0:63];
  logic [3:0] addr_reg; // Latched burst location
  logic [1:0] beat_reg; // Next word index within the burst
  logic [1:0] beat_next; // Word index after this beat
  logic active_reg; // Burst data phase in progress
  logic [35:0] rd_data_reg; // Read-back word register
  logic wr_done_reg; // Write report register
  lane_mask_pkg::part_t part; // Decoded part configuration
  // Bit enables derived from the selects of this beat
  logic [35:0] bit_en;
  logic [5:0] wr_idx; // Array word the beat targets
  logic any_en; // At least one lane enabled
  logic beat_ok; // Beat taken into the burst

  // Expand a 4-bit lane enable into 36 bit enables, nine bits a lane
  function automatic logic [35:0] expand_lanes(input logic [3:0] en);
    logic [35:0] r;
    r = '0;
    for (int i = 0; i < lane_mask_pkg::LANES; i++)
    begin
      r[i*lane_mask_pkg::LANE_W +: lane_mask_pkg::LANE_W] = {lane_mask_pkg::LANE_W{en[i]}};
    end
    return r;
  endfunction

  assign part = lane_mask_pkg::part_t'(part_sel);
  always_comb
  begin
    bit_en = '0; // Nothing written unless a lane is selected
    unique case (part)
      lane_mask_pkg::PART_X8:
        bit_en = {28'h0, {4{~half_word_write_select_n[1]}}, {4{~half_word_write_select_n[0]}}};
      lane_mask_pkg::PART_X9:
        bit_en = expand_lanes({3'h0, ~lane_write_select_n[0]});
      lane_mask_pkg::PART_X18:
        bit_en = expand_lanes({2'h0, ~lane_write_select_n[1:0]});
      lane_mask_pkg::PART_X36:
        bit_en = expand_lanes(~lane_write_select_n);
    endcase
  end

  AST_X8_BOTH: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X8 && half_word_write_select_n == 2'h0) |-> bit_en == 36'h0FF)
    else $error("nibble full mask wrong");
  AST_X8_LOW: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X8 && half_word_write_select_n == 2'h2) |-> bit_en == 36'h00F)
    else $error("lower nibble mask wrong");
  AST_X8_HIGH: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X8 && half_word_write_select_n == 2'h1) |-> bit_en == 36'h0F0)
    else $error("upper nibble mask wrong");
  AST_X8_NONE: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X8 && half_word_write_select_n == 2'h3) |-> bit_en == 36'h0)
    else $error("nibble mask not empty");
  AST_X9: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X9 && !lane_write_select_n[0]) |-> bit_en == 36'h1FF)
    else $error("nine-bit mask wrong");
  AST_X9_NONE: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X9 && lane_write_select_n[0]) |-> bit_en == 36'h0)
    else $error("nine-bit mask not empty");
  AST_X18_BOTH: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X18 && lane_write_select_n[1:0] == 2'h0)
      |-> bit_en == 36'h3FFFF)
    else $error("byte full mask wrong");
  AST_X18_LOW: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X18 && lane_write_select_n[1:0] == 2'h2)
      |-> bit_en == 36'h001FF)
    else $error("lower byte mask wrong");
  AST_X18_HIGH: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X18 && lane_write_select_n[1:0] == 2'h1)
      |-> bit_en == 36'h3FE00)
    else $error("upper byte mask wrong");
  AST_X18_NONE: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X18 && lane_write_select_n[1:0] == 2'h3)
      |-> bit_en == 36'h0)
    else $error("byte mask not empty");
  AST_X36_ALL: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X36 && lane_write_select_n == 4'h0) |-> &bit_en)
    else $error("full mask wrong");
  AST_X36_LANE0: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X36 && lane_write_select_n == 4'hE) |-> bit_en == 36'h0000001FF)
    else $error("lane 0 mask wrong");
  AST_X36_LANE1: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X36 && lane_write_select_n == 4'hD) |-> bit_en == 36'h00003FE00)
    else $error("lane 1 mask wrong");
  AST_X36_LANE2: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X36 && lane_write_select_n == 4'hB) |-> bit_en == 36'h007FC0000)
    else $error("lane 2 mask wrong");
  AST_X36_LANES: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X36 && lane_write_select_n == 4'h7) |-> bit_en == 36'hFF8000000)
    else $error("lane 3 mask wrong");
  AST_X36_NONE: assert property (@(posedge clk_sys) disable iff (reset)
    (part == lane_mask_pkg::PART_X36 && lane_write_select_n == 4'hF) |-> bit_en == 36'h0)
    else $error("wide mask not empty");

  // All selects high leaves the array untouched
  assign any_en = |bit_en;
  // Address cycle and reset win over a beat in the same cycle, so a dropped beat never writes
  assign beat_ok = beat_valid && active_reg && !burst_start && !reset;
  // Beat index picks its own burst word
  assign wr_idx = {addr_reg, beat_reg};
  assign beat_next = beat_reg + 2'h1;

  // Burst sequencing: four beats after the address cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      active_reg <= 1'b0;
      beat_reg <= lane_mask_pkg::BEAT_RST;
      addr_reg <= lane_mask_pkg::ADDR_RST;
    end
    else if (burst_start)
    begin
      active_reg <= 1'b1;
      beat_reg <= lane_mask_pkg::BEAT_RST;
      addr_reg <= burst_addr;
    end
    else if (beat_ok)
    begin
      // Last beat closes the burst; extra beats are ignored
      beat_reg <= beat_next;
      if (beat_reg == lane_mask_pkg::BEAT_LAST)
      begin
        active_reg <= 1'b0;
      end
    end
  end

  AST_BEAT_ADV: assert property (@(posedge clk_sys) disable iff (reset)
    (beat_ok && !burst_start) |=> beat_reg == $past(beat_reg) + 2'h1)
    else $error("beat index did not advance");
  AST_FOUR_BEATS: assert property (@(posedge clk_sys) disable iff (reset)
    (beat_ok && beat_reg == lane_mask_pkg::BEAT_LAST && !burst_start) |=> !active_reg)
    else $error("burst not closed after fourth beat");
  AST_START: assert property (@(posedge clk_sys) disable iff (reset)
    burst_start |=> active_reg && beat_reg == 2'h0)
    else $error("burst start not taken");
  AST_IDLE_BEAT: assert property (@(posedge clk_sys) disable iff (reset)
    (beat_valid && !active_reg && !burst_start) |=> !wr_done)
    else $error("beat outside a burst was written");

  // Mask merge: each bit keeps old value unless enabled this beat
  always_ff @(posedge clk_sys)
  begin
    if (beat_ok && any_en)
    begin
      mem_reg[wr_idx] <= (beat_data & bit_en) | (mem_reg[wr_idx] & ~bit_en);
    end
  end

  // Read-back and completion pulse; no array reset exists, matching the part
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rd_data_reg <= lane_mask_pkg::WORD_RST;
      wr_done_reg <= 1'b0;
    end
    else
    begin
      rd_data_reg <= mem_reg[{rd_addr, rd_beat}];
      wr_done_reg <= beat_ok && any_en;
    end
  end

  assign rd_data = rd_data_reg;
  assign wr_done = wr_done_reg;

  AST_NO_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
    (beat_ok && !any_en) |=> !wr_done)
    else $error("write reported with all selects high");
  AST_DONE: assert property (@(posedge clk_sys) disable iff (reset)
    (beat_ok && any_en) |=> wr_done)
    else $error("enabled beat not written");
endmodule // burst_write_lane_mask

//--- testbench/mem_ctl_model.sv
// Memory controller model: drives write bursts into the lane mask block.
// Assumes the bench calls burst() only while no other burst runs.
`timescale 1ns/1ps
module mem_ctl_model
(
  input wire logic clk_sys, // System clock
  input wire logic wr_done, // Beat written pulse
  output logic burst_start, // Address strobe
  output logic [3:0] burst_addr, // Burst location
  output logic beat_valid, // Beat strobe
  output logic [35:0] beat_data, // Beat data
  output logic [3:0] lane_write_select_n, // Lane selects
  output logic [1:0] half_word_write_select_n // Nibble selects
);
  logic [3:0] seen; // Done pulse seen after each beat
  // Idle at time zero
  initial
  begin
    {burst_start, beat_valid, burst_addr, seen} = 10'h0;
    {beat_data, lane_write_select_n, half_word_write_select_n} = 42'h0;
  end
  task automatic burst(input logic [3:0] a, input logic [143:0] d,
    input logic [15:0] s, input logic [7:0] h);
    @(posedge clk_sys);
    #1 burst_start = 1'h1;
    burst_addr = a;
    for (int k = 0; k < 5; k++)
    begin
      @(posedge clk_sys);
      #1 burst_start = 1'h0;
      if (k > 0) seen[k-1] = wr_done;
      beat_valid = (k < 4);
      if (k < 4)
      begin
        beat_data = d[36*k+:36];
        lane_write_select_n = s[4*k+:4];
        half_word_write_select_n = h[2*k+:2];
      end
      else
      begin
        // Released data and address lines show the inverse, not a stale value; selects keep the last beat
        beat_data = ~beat_data;
        burst_addr = ~burst_addr;
      end
    end
  endtask
endmodule // mem_ctl_model

//--- testbench/tb.sv
// Bench for burst_write_lane_mask on all four part widths.
// Assumes mem_ctl_model writes; the bench reads back and judges.
`timescale 1ns/1ps
module tb;
  localparam logic [35:0] OLD = 36'hA5A5A5A5A; // Prefill word
  localparam logic [35:0] NEW = 36'h5A5A5A5A5; // Complement, so kept bits show
  logic clk_sys, reset, wr_done; // Clock, reset, done
  logic [1:0] part_sel, rd_beat; // Part code, read word
  logic [3:0] rd_addr; // Read location
  logic [35:0] rd_data; // Read-back word
  wire burst_start, beat_valid; // Strobes from model
  wire [3:0] burst_addr, lane_write_select_n; // Address, lane selects
  wire [1:0] half_word_write_select_n; // Nibble selects
  wire [35:0] beat_data; // Beat data
  int miscompares = 0; // Mismatches
  int total_checks = 0; // Comparisons
  burst_write_lane_mask u_dut (.clk_sys, .reset, .part_sel, .burst_start, .burst_addr,
    .beat_valid, .beat_data, .lane_write_select_n, .half_word_write_select_n,
    .rd_addr, .rd_beat, .rd_data, .wr_done);
  mem_ctl_model u_ctl (.clk_sys, .wr_done, .burst_start, .burst_addr, .beat_valid,
    .beat_data, .lane_write_select_n, .half_word_write_select_n);
  // Free-running 100 MHz clock
  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Enabled bits of a beat, per part width
  function automatic logic [35:0] lmask(input logic [1:0] p, input logic [3:0] s,
    input logic [1:0] h);
    case (p)
      2'h0: lmask = {28'h0, {4{~h[1]}}, {4{~h[0]}}};
      2'h1: lmask = {27'h0, {9{~s[0]}}};
      2'h2: lmask = {18'h0, {9{~s[1]}}, {9{~s[0]}}};
      default: lmask = {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
    endcase
  endfunction
  // Prefill wide, then masked burst; read every word back
  task automatic run(input logic [1:0] p, input logic [3:0] a, input logic [15:0] s,
    input logic [7:0] h);
    logic [35:0] m;
    part_sel = 2'h3;
    u_ctl.burst(a, {4{OLD}}, 16'h0, 8'h0);
    part_sel = p;
    u_ctl.burst(a, {4{NEW}}, s, h);
    for (int k = 0; k < 4; k++)
    begin
      m = lmask(p, s[4*k+:4], h[2*k+:2]);
      check("wr_done", {35'h0, u_ctl.seen[k]}, {35'h0, |m});
      rd_addr = a;
      rd_beat = k[1:0];
      @(posedge clk_sys);
      #1 check("rd_data", rd_data, (OLD & ~m) | (NEW & m));
    end
  endtask
  // all lanes, then one lane per beat; then mixed
  task automatic t_wide;
    run(2'h3, 4'h1, 16'hBDE0, 8'h0);
    run(2'h3, 4'h2, 16'hF5F7, 8'h0);
  endtask
  // byte selects, upper select bits held high
  task automatic t_half;
    run(2'h2, 4'h7, 16'hFDEC, 8'hFF);
  endtask
  task automatic t_nib;
    run(2'h0, 4'h9, 16'h0, 8'hD8);
  endtask
  task automatic t_nine;
    run(2'h1, 4'hE, 16'hF01E, 8'h0);
  endtask
  // burst cut by reset in mid-run: only the first beat lands
  task automatic t_reset;
    part_sel = 2'h3;
    u_ctl.burst(4'h3, {4{OLD}}, 16'h0, 8'h0);
    fork
      u_ctl.burst(4'h3, {4{NEW}}, 16'h0, 8'h0);
      begin
        // Reset is sampled with the second beat; later beats find no burst
        repeat (3) @(posedge clk_sys);
        #1 reset = 1'h1;
        @(posedge clk_sys);
        #1 reset = 1'h0;
        check("wr_done", {35'h0, wr_done}, 36'h0);
        check("rd_data", rd_data, 36'h0);
      end
    join
    for (int k = 0; k < 4; k++)
    begin
      check("wr_done", {35'h0, u_ctl.seen[k]}, {35'h0, k == 0});
      rd_addr = 4'h3;
      rd_beat = k[1:0];
      @(posedge clk_sys);
      #1 check("rd_data", rd_data, (k == 0) ? NEW : OLD);
    end
  endtask
  // Reset, then the scenarios
  initial
  begin
    {reset, part_sel, rd_addr, rd_beat} = 9'h100;
    repeat (12) @(posedge clk_sys);
    #1 reset = 1'h0;
    check("rd_data", rd_data, 36'h0);
    t_wide();
    t_half();
    t_nib();
    t_nine();
    t_reset();
    results();
  end
  // Watchdog, far beyond the roughly 110 cycles needed
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    miscompares++;
    results();
  end
endmodule // tb
